//--- acs_converter_model.sv
`timescale 1ns/1ps
// Converter stand-in: answers each start that is not aborted or restarted after a set number of cycles
module acs_converter_model
    import acs_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic conv_start,
    input wire logic conv_abort,
    input wire logic [7:0] latency,
    output logic conv_done
);
    logic busy;
    logic [7:0] cnt;

    // Start loads the latency, abort drops the job, done pulses once
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            cnt <= 8'h00;
            conv_done <= 1'b0;
        end else begin
            conv_done <= 1'b0;
            if (conv_start) begin
                busy <= 1'b1;
                cnt <= latency;
            end else if (conv_abort) begin
                busy <= 1'b0; // Aborted job never reports done
            end else if (busy) begin
                if (cnt == 8'h00) begin
                    busy <= 1'b0;
                    conv_done <= 1'b1;
                end else begin
                    cnt <= cnt - 8'h01;
                end
            end
        end
    end
endmodule

//--- acs_pkg.sv
package acs_pkg;
    // Register byte offsets
    localparam logic [4:0] ACS_OFS_GLOBAL = 5'h00;
    localparam logic [4:0] ACS_OFS_SCAN = 5'h04;
    localparam logic [4:0] ACS_OFS_DELAY = 5'h08;
    localparam logic [4:0] ACS_OFS_CMD = 5'h0C;
    localparam logic [4:0] ACS_OFS_STATUS = 5'h10;
    // global_setup_reg fields
    localparam int ACS_GS_EXT_TRIG = 0;
    localparam int ACS_GS_CLK_SRC_LO = 1;
    localparam int ACS_GS_CLKOUT_EN = 3;
    localparam logic [1:0] ACS_CLK_SRC_EXT = 2'h1;
    // Command register fields and codes
    localparam int ACS_CMD_CH_LO = 4;
    localparam logic [2:0] ACS_CMD_ONE_ONCE = 3'h1;
    localparam logic [2:0] ACS_CMD_ONE_LOOP = 3'h2;
    localparam logic [2:0] ACS_CMD_SCAN_ONCE = 3'h3;
    localparam logic [2:0] ACS_CMD_SCAN_PASS = 3'h4;
    localparam logic [2:0] ACS_CMD_SCAN_LOOP = 3'h5;
    localparam logic [2:0] ACS_CMD_STOP = 3'h6;
    localparam logic [2:0] ACS_CMD_ABORT = 3'h7;
    // Status register fields
    localparam int ACS_ST_BUSY = 4;
    localparam int ACS_ST_READY = 5;
    localparam int ACS_ST_MODE_LO = 6;
    // Values after reset
    localparam logic [15:0] ACS_MASK_RST = 16'h0001;
    localparam logic [15:0] ACS_DELAY_RST = 16'h0000;
    // Fixed setup delay of the first reading, in system clock cycles
    localparam int ACS_FIXED_CYC = 2;
    localparam logic [15:0] ACS_FIXED_CNT = 16'(ACS_FIXED_CYC - 1);

    typedef enum logic [2:0] {
        ACS_IDLE, ACS_SETUP, ACS_DELAY, ACS_CONV
    } acs_state_t;

    typedef enum logic [2:0] {
        ACS_ONE_ONCE, ACS_ONE_LOOP, ACS_SCAN_ONCE, ACS_SCAN_PASS, ACS_SCAN_LOOP
    } acs_mode_t;

    typedef struct packed {
        acs_state_t st;
        acs_mode_t mode;
        logic [3:0] ptr;
        logic [15:0] cnt;
        logic first;
        logic stop_req;
        logic rdy;
        logic start_p;
        logic abort_p;
        logic [2:0] trig_s;
        logic ext_trig;
        logic [1:0] clk_sel;
        logic clkout_en;
        logic [15:0] mask;
        logic [15:0] dly;
        logic [3:0] one_ch;
        logic wr_ph;
        logic [4:0] addr;
        logic [31:0] rdata;
        logic clk_div;
    } acs_core_t;
endpackage

//--- acs_sequencer.sv
`timescale 1ns/1ps
// Function
// R1: Pin trigger selected: rising edge starts conversion
// R2: Trigger during conversion aborts and restarts
// R3: Host holds trigger high two clocks
// R4: Pin trigger deselected: trigger pin ignored
// R5: Command trigger: command write starts conversion
// R6: Pin trigger: command only selects mode
// R7: Five reading modes, one command each
// R8: Pin trigger works in every mode
// R9: Start updates pointer, then programmable delay
// R10: Four-bit pointer shows converting channel
// R11: Scan modes advance to next enabled channel
// R12: Single-reading modes return idle after reading
// R13: Continuous modes loop back to setup
// R14: Pass mode ends after last enabled channel
// R15: Stop lets current conversion finish
// R16: Abort ends reading process at once
// R17: Command trigger: new command restarts process
// R18: Result ready raised when reading completes
// R19: Clock source select picks external clock
// R20: Clock output enable drives aux pin nine
// R21: Channels visited in ascending index order
// R22: Fixed delay only on first reading
// R23: Trigger pin synchronised, edges by comparison
// R24: Stop or abort while idle does nothing
module acs_sequencer
    import acs_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic trigger_pin,
    input wire logic conv_done,
    output logic conv_start,
    output logic conv_abort,
    output logic [3:0] active_channel_pointer,
    output logic result_ready_line,
    output logic clock_source_ext,
    output logic aux_pin_nine_o,
    output logic aux_pin_nine_oe
);

    acs_core_t q;
    acs_core_t n;
    logic trig_edge;
    logic cmd_wr;
    logic [2:0] cmd_code;
    logic cmd_start;
    logic cmd_stop;
    logic cmd_abort;
    logic start_evt;
    logic scan_mode;
    logic [4:0] first_ch;
    logic [4:0] next_up;
    logic [4:0] next_wrap;

    // Next enabled channel after 'from', lowest index first
    function automatic logic [4:0] next_ch(input logic [15:0] m, input logic [3:0] from,
                                           input logic wrap);
        logic [4:0] r;
        logic [3:0] j;
        r = '0;
        for (int k = 16; k >= 1; k--) begin
            j = from + k[3:0];
            if (m[j] && (wrap || j > from)) begin
                r = {1'b1, j};
            end
        end
        return r;
    endfunction

    // Command decode from the data phase of a write
    assign cmd_wr = q.wr_ph && (q.addr == ACS_OFS_CMD);
    assign cmd_code = hwdata[2:0];
    assign cmd_start = cmd_wr && (cmd_code >= ACS_CMD_ONE_ONCE) && (cmd_code <= ACS_CMD_SCAN_LOOP);
    assign cmd_stop = cmd_wr && (cmd_code == ACS_CMD_STOP);
    assign cmd_abort = cmd_wr && (cmd_code == ACS_CMD_ABORT);
    // Edge from the second and third samples only
    assign trig_edge = q.ext_trig && q.trig_s[1] && !q.trig_s[2]; // R1 R4 R23
    // Start source depends on trigger select
    assign start_evt = q.ext_trig ? trig_edge : cmd_start; // R5 R6 R8 R17
    assign scan_mode = (q.mode == ACS_SCAN_ONCE) || (q.mode == ACS_SCAN_PASS) ||
                       (q.mode == ACS_SCAN_LOOP);
    assign first_ch = next_ch(q.mask, 4'hF, 1'b1); // R21
    assign next_up = next_ch(q.mask, q.ptr, 1'b0); // R11 R21
    assign next_wrap = next_ch(q.mask, q.ptr, 1'b1); // R11 R21

    // Bus slave, register file and sequencer next state
    always_comb begin
        n = q;
        n.start_p = 1'b0;
        n.abort_p = 1'b0;
        // Trigger pin synchroniser and edge history
        n.trig_s = {q.trig_s[1:0], trigger_pin}; // R23
        // System clock divided by two for the aux pin
        n.clk_div = q.clkout_en ? !q.clk_div : 1'b0; // R20
        // Address phase capture
        n.wr_ph = hsel && htrans[1] && hready && hwrite;
        n.addr = haddr[4:0];
        if (hsel && htrans[1] && hready && !hwrite) begin
            unique case (haddr[4:0])
                ACS_OFS_GLOBAL: n.rdata = {28'h0, q.clkout_en, q.clk_sel, q.ext_trig};
                ACS_OFS_SCAN: n.rdata = {16'h0, q.mask};
                ACS_OFS_DELAY: n.rdata = {16'h0, q.dly};
                ACS_OFS_CMD: n.rdata = {24'h0, q.one_ch, 1'b0, 3'h0};
                ACS_OFS_STATUS: n.rdata = {23'h0, q.mode, q.rdy, q.st != ACS_IDLE, q.ptr};
                default: n.rdata = 32'h0;
            endcase
        end
        // Data phase register writes
        if (q.wr_ph) begin
            unique case (q.addr)
                ACS_OFS_GLOBAL: begin
                    n.ext_trig = hwdata[ACS_GS_EXT_TRIG];
                    n.clk_sel = hwdata[ACS_GS_CLK_SRC_LO +: 2]; // R19
                    n.clkout_en = hwdata[ACS_GS_CLKOUT_EN];
                end
                ACS_OFS_SCAN: n.mask = hwdata[15:0];
                ACS_OFS_DELAY: n.dly = hwdata[15:0];
                default: begin
                end
            endcase
        end
        // A start command always selects the reading mode
        if (cmd_start) begin
            n.one_ch = hwdata[ACS_CMD_CH_LO +: 4];
            unique case (cmd_code)
                ACS_CMD_ONE_ONCE: n.mode = ACS_ONE_ONCE; // R7
                ACS_CMD_ONE_LOOP: n.mode = ACS_ONE_LOOP; // R7
                ACS_CMD_SCAN_ONCE: n.mode = ACS_SCAN_ONCE; // R7
                ACS_CMD_SCAN_PASS: n.mode = ACS_SCAN_PASS; // R7
                default: n.mode = ACS_SCAN_LOOP; // R7
            endcase
        end
        // Sequencer: a start beats stop, abort and completion
        if (start_evt) begin
            n.abort_p = (q.st == ACS_CONV); // R2 R17
            n.st = ACS_SETUP; // R1 R5 R9
            n.first = 1'b1;
            n.cnt = ACS_FIXED_CNT; // R22
            n.rdy = 1'b0;
            n.stop_req = 1'b0;
            if (q.ext_trig ? scan_mode : (cmd_code >= ACS_CMD_SCAN_ONCE)) begin
                n.ptr = first_ch[3:0]; // R9 R21
                if (!first_ch[4]) begin
                    n.st = ACS_IDLE;
                end
            end else begin
                n.ptr = q.ext_trig ? q.one_ch : hwdata[ACS_CMD_CH_LO +: 4]; // R9
            end
        end else if (cmd_abort) begin
            n.abort_p = (q.st == ACS_CONV); // R16
            n.st = ACS_IDLE; // R16 R24
        end else begin
            unique case (q.st)
                ACS_IDLE: begin
                    n.stop_req = 1'b0; // R24
                end
                ACS_SETUP: begin
                    if (cmd_stop) begin
                        n.st = ACS_IDLE; // R15
                    end else if (q.cnt == 16'h0) begin
                        n.st = ACS_DELAY; // R9
                        n.cnt = q.dly;
                    end else begin
                        n.cnt = q.cnt - 16'h1;
                    end
                end
                ACS_DELAY: begin
                    if (cmd_stop) begin
                        n.st = ACS_IDLE; // R15
                    end else if (q.cnt == 16'h0) begin
                        n.st = ACS_CONV; // R9
                        n.start_p = 1'b1;
                    end else begin
                        n.cnt = q.cnt - 16'h1;
                    end
                end
                ACS_CONV: begin
                    if (cmd_stop) begin
                        n.stop_req = 1'b1; // R15
                    end
                    if (conv_done) begin
                        n.rdy = 1'b1; // R18
                        n.first = 1'b0;
                        n.cnt = 16'h0; // R22
                        n.st = ACS_SETUP;
                        unique case (q.mode)
                            ACS_ONE_ONCE: n.st = ACS_IDLE; // R12
                            ACS_ONE_LOOP: n.st = ACS_SETUP; // R13
                            ACS_SCAN_ONCE: begin
                                n.st = ACS_IDLE; // R12
                                n.ptr = next_wrap[3:0]; // R11
                            end
                            ACS_SCAN_PASS: begin
                                n.ptr = next_up[3:0]; // R11 R14
                                if (!next_up[4]) begin
                                    n.st = ACS_IDLE; // R14
                                    n.ptr = q.ptr;
                                end
                            end
                            default: n.ptr = next_wrap[3:0]; // R11 R13
                        endcase
                        if (q.stop_req || cmd_stop) begin
                            n.st = ACS_IDLE; // R15
                        end
                    end
                end
                default: n.st = ACS_IDLE;
            endcase
        end
    end

    // State register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{st: ACS_IDLE, mode: ACS_ONE_ONCE, mask: ACS_MASK_RST,
                   dly: ACS_DELAY_RST, default: '0};
        end else begin
            q <= n;
        end
    end

    // Outputs
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = q.rdata;
    assign conv_start = q.start_p;
    assign conv_abort = q.abort_p;
    assign active_channel_pointer = q.ptr; // R10
    assign result_ready_line = q.rdy; // R18
    assign clock_source_ext = (q.clk_sel == ACS_CLK_SRC_EXT); // R19
    assign aux_pin_nine_o = q.clk_div; // R20
    assign aux_pin_nine_oe = q.clkout_en; // R20

    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    logic quiet;
    assign quiet = !start_evt && !cmd_abort && !cmd_stop && !q.stop_req;

    sequence s_read_done;
        q.st == ACS_CONV && conv_done && quiet;
    endsequence

    sequence s_loop_back;
        q.st == ACS_SETUP && q.cnt == 16'h0 && !q.first;
    endsequence

    property p_trig_start;
        trig_edge && q.mode == ACS_ONE_ONCE |=> q.st == ACS_SETUP && q.first;
    endproperty
    a_trig_start: assert property (p_trig_start) else $error("trigger edge not started"); // R1

    property p_trig_restart;
        trig_edge && q.st == ACS_CONV |=> conv_abort;
    endproperty
    a_trig_restart: assert property (p_trig_restart) else $error("busy trigger no abort"); // R2

    property p_trig_ignored;
        !q.ext_trig && !cmd_wr && q.st == ACS_IDLE |=> q.st == ACS_IDLE;
    endproperty
    a_trig_ignored: assert property (p_trig_ignored) else $error("idle left without start"); // R4

    property p_cmd_start;
        !q.ext_trig && cmd_start && cmd_code == ACS_CMD_ONE_LOOP
            |=> q.st == ACS_SETUP && q.cnt == ACS_FIXED_CNT;
    endproperty
    a_cmd_start: assert property (p_cmd_start) else $error("command did not start"); // R5

    property p_cmd_mode_only;
        q.ext_trig && cmd_start && !trig_edge && q.st == ACS_IDLE |=> q.st == ACS_IDLE;
    endproperty
    a_cmd_mode_only: assert property (p_cmd_mode_only) else $error("command started"); // R6

    property p_once_idle;
        s_read_done and (q.mode == ACS_ONE_ONCE) |=> q.st == ACS_IDLE && result_ready_line;
    endproperty
    a_once_idle: assert property (p_once_idle) else $error("single reading not idle"); // R12

    property p_loop_back;
        s_read_done and (q.mode == ACS_ONE_LOOP) |=> s_loop_back;
    endproperty
    a_loop_back: assert property (p_loop_back) else $error("loop kept fixed delay"); // R22

    property p_scan_ascend;
        s_read_done and (q.mode == ACS_SCAN_PASS) |=> q.ptr > $past(q.ptr) || q.st == ACS_IDLE;
    endproperty
    a_scan_ascend: assert property (p_scan_ascend) else $error("scan order wrong"); // R21

    property p_abort_idle;
        cmd_abort && !start_evt |=> q.st == ACS_IDLE ##1 !conv_start;
    endproperty
    a_abort_idle: assert property (p_abort_idle) else $error("abort not idle"); // R16

    property p_delay_conv;
        q.st == ACS_DELAY && q.cnt == 16'h0 && quiet |=> conv_start && q.st == ACS_CONV;
    endproperty
    a_delay_conv: assert property (p_delay_conv) else $error("conversion not started"); // R9

    property p_ready_set;
        s_read_done |=> result_ready_line;
    endproperty
    a_ready_set: assert property (p_ready_set) else $error("ready not raised"); // R18

    property p_pass_end;
        s_read_done and (q.mode == ACS_SCAN_PASS && (q.mask >> q.ptr) == 16'h0001)
            |=> q.st == ACS_IDLE;
    endproperty
    a_pass_end: assert property (p_pass_end) else $error("pass went past last channel"); // R14

    property p_loop_next;
        s_read_done and (q.mode == ACS_SCAN_LOOP) |=> q.st == ACS_SETUP && q.mask[q.ptr];
    endproperty
    a_loop_next: assert property (p_loop_next) else $error("scan loop did not repeat"); // R13

    property p_stop_finish;
        q.st == ACS_CONV && q.stop_req && conv_done && !start_evt && !cmd_abort
            |=> q.st == ACS_IDLE;
    endproperty
    a_stop_finish: assert property (p_stop_finish) else $error("stop did not end process"); // R15

    property p_abort_conv;
        cmd_abort && !start_evt && q.st == ACS_CONV |=> conv_abort && q.st == ACS_IDLE;
    endproperty
    a_abort_conv: assert property (p_abort_conv) else $error("running job not dropped"); // R16

    property p_idle_cmds;
        q.st == ACS_IDLE && (cmd_stop || cmd_abort) && !start_evt
            |=> q.st == ACS_IDLE && !conv_abort;
    endproperty
    a_idle_cmds: assert property (p_idle_cmds) else $error("idle stop or abort acted"); // R24

    property p_cmd_restart;
        !q.ext_trig && cmd_start && q.st == ACS_CONV |=> conv_abort;
    endproperty
    a_cmd_restart: assert property (p_cmd_restart) else $error("restart kept old job"); // R17

    property p_clk_out;
        q.clkout_en |=> aux_pin_nine_o == !$past(aux_pin_nine_o);
    endproperty
    a_clk_out: assert property (p_clk_out) else $error("aux clock not toggling"); // R20
endmodule

//--- testbench.sv
`timescale 1ns/1ps
module testbench
    import acs_pkg::*;
;
    logic mclk, rst_n, hsel, hwrite, trigger_pin, conv_done, conv_start, conv_abort, t;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] latency;
    logic hreadyout, hresp, result_ready_line, clock_source_ext, aux_o, aux_oe, hready_bus;
    logic [3:0] active_channel_pointer;
    logic [3:0] ptrs[$];
    int fail_count, checked, n_start, n_abort, k, s0, a0;

    assign hready_bus = hreadyout;

    acs_sequencer acs_sequencer_inst (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready_bus),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .trigger_pin(trigger_pin),
        .conv_done(conv_done), .conv_start(conv_start), .conv_abort(conv_abort),
        .active_channel_pointer(active_channel_pointer), .result_ready_line(result_ready_line),
        .clock_source_ext(clock_source_ext), .aux_pin_nine_o(aux_o), .aux_pin_nine_oe(aux_oe));

    acs_converter_model acs_converter_model_inst (.mclk(mclk), .rst_n(rst_n),
        .conv_start(conv_start), .conv_abort(conv_abort), .latency(latency),
        .conv_done(conv_done));

    // Clock generation
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // Log every start with its channel, count aborts
    always @(posedge mclk) begin
        if (conv_start === 1'b1) begin
            n_start <= n_start + 1;
            ptrs.push_back(active_channel_pointer);
        end
        if (conv_abort === 1'b1) begin
            n_abort <= n_abort + 1;
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %08h expected %08h", $time, got, exp);
        end
    endtask

    // One AHB-Lite single transfer, read data left in rd
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= {27'h0000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge mclk); while (hready_bus !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hready_bus !== 1'b1);
        rd = hrdata;
    endtask

    task automatic cmd(input logic [2:0] code, input logic [3:0] ch);
        bus(1'b1, ACS_OFS_CMD, {24'h000000, ch, 1'b0, code});
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic wait_start(input int tgt);
        k = 0;
        while (n_start < tgt && k < 500) begin
            @(posedge mclk);
            k++;
        end
        check(32'(n_start), 32'(tgt));
    endtask

    // Trigger pulse of four system clocks, well over the two required
    task automatic pulse();
        trigger_pin <= 1'b1;
        idle(4);
        trigger_pin <= 1'b0;
        idle(4);
    endtask

    task automatic check_ptrs(input int n, input logic [31:0] seq);
        check(32'(ptrs.size()), 32'(n));
        for (int i = 0; i < n; i++) begin
            check({28'h0000000, ptrs[i]}, {28'h0000000, seq[4*i+:4]});
        end
    endtask

    task automatic check_busy(input logic exp);
        bus(1'b0, ACS_OFS_STATUS, 32'h00000000);
        check({31'h00000000, rd[ACS_ST_BUSY]}, {31'h00000000, exp});
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        $display("watchdog expired at %0t", $time);
        finish_test();
    end

    // Main sequence
    initial begin
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        trigger_pin = 1'b0;
        latency = 8'h03;
        rst_n = 1'b0;
        fail_count = 0;
        checked = 0;
        n_start = 0;
        n_abort = 0;
        idle(4);
        rst_n <= 1'b1;
        // Reset values, unmapped place, readback
        bus(1'b0, ACS_OFS_GLOBAL, 32'h0);
        check(rd, 32'h00000000);
        bus(1'b0, ACS_OFS_SCAN, 32'h0);
        check(rd, {16'h0000, ACS_MASK_RST});
        bus(1'b0, ACS_OFS_STATUS, 32'h0);
        check(rd, 32'h00000000);
        bus(1'b1, 5'h14, 32'hFFFFFFFF);
        bus(1'b0, 5'h14, 32'h0);
        check(rd, 32'h00000000);
        check({31'h0, hresp}, 32'h00000000);
        bus(1'b1, ACS_OFS_DELAY, 32'h00000005);
        bus(1'b0, ACS_OFS_DELAY, 32'h0);
        check(rd, 32'h00000005);
        $display("test reset_and_map done");
        // Command start timing and single reading
        ptrs.delete();
        cmd(ACS_CMD_ONE_ONCE, 4'h3);
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (conv_start !== 1'b1 && k < 100);
        check(32'(k), 32'(ACS_FIXED_CYC + 5 + 2));
        idle(12);
        check_ptrs(1, 32'h00000003);
        check({31'h0, result_ready_line}, 32'h00000001);
        check_busy(1'b0);
        bus(1'b1, ACS_OFS_DELAY, 32'h00000000);
        $display("test one_channel_once done");
        // Scan once and scan pass over channels 1 and 4
        bus(1'b1, ACS_OFS_SCAN, 32'h00000012);
        ptrs.delete();
        cmd(ACS_CMD_SCAN_ONCE, 4'h0);
        idle(30);
        check_ptrs(1, 32'h00000001);
        check({28'h0, active_channel_pointer}, 32'h00000004);
        ptrs.delete();
        cmd(ACS_CMD_SCAN_PASS, 4'h0);
        idle(40);
        check_ptrs(2, 32'h00000041);
        check_busy(1'b0);
        $display("test scan_once_pass done");
        // Scan loop, restart by command, then stop
        bus(1'b1, ACS_OFS_SCAN, 32'h00001050);
        latency = 8'h1E;
        ptrs.delete();
        s0 = n_start;
        a0 = n_abort;
        cmd(ACS_CMD_SCAN_LOOP, 4'h0);
        wait_start(s0 + 2);
        idle(5);
        cmd(ACS_CMD_SCAN_LOOP, 4'h0);
        wait_start(s0 + 6);
        check(32'(n_abort - a0), 32'h00000001);
        check_ptrs(6, 32'h004C6464);
        idle(3);
        cmd(ACS_CMD_STOP, 4'h0);
        idle(60);
        check_ptrs(6, 32'h004C6464);
        check(32'(n_abort - a0), 32'h00000001);
        check_busy(1'b0);
        $display("test scan_loop_stop done");
        // Abort in mid conversion, then stop and abort while idle
        s0 = n_start;
        a0 = n_abort;
        cmd(ACS_CMD_ONE_LOOP, 4'h9);
        wait_start(s0 + 1);
        idle(3);
        cmd(ACS_CMD_ABORT, 4'h0);
        idle(5);
        check(32'(n_abort - a0), 32'h00000001);
        check_busy(1'b0);
        idle(40);
        check(32'(n_start), 32'(s0 + 1));
        cmd(ACS_CMD_ABORT, 4'h0);
        cmd(ACS_CMD_STOP, 4'h0);
        idle(10);
        check(32'(n_abort - a0), 32'h00000001);
        check(32'(n_start), 32'(s0 + 1));
        $display("test abort done");
        // Pin trigger in every mode; commands only pick the mode
        latency = 8'h03;
        bus(1'b1, ACS_OFS_GLOBAL, 32'h00000001);
        for (int c = 1; c <= 5; c++) begin
            s0 = n_start;
            cmd(3'(c), 4'h2);
            idle(10);
            check(32'(n_start), 32'(s0));
            bus(1'b0, ACS_OFS_STATUS, 32'h0);
            check({29'h0, rd[ACS_ST_MODE_LO+:3]}, 32'(c - 1));
            pulse();
            wait_start(s0 + 1);
            // Let looping modes repeat a few readings before the abort
            idle(20);
            if (c == 2 || c == 5) begin
                check(32'(n_start - s0 >= 2), 32'h00000001);
            end
            cmd(ACS_CMD_ABORT, 4'h0);
            idle(10);
        end
        latency = 8'h1E;
        s0 = n_start;
        a0 = n_abort;
        cmd(ACS_CMD_ONE_LOOP, 4'h2);
        pulse();
        wait_start(s0 + 1);
        pulse();
        wait_start(s0 + 2);
        check(32'(n_abort - a0), 32'h00000001);
        cmd(ACS_CMD_ABORT, 4'h0);
        bus(1'b1, ACS_OFS_GLOBAL, 32'h00000000);
        s0 = n_start;
        pulse();
        idle(20);
        check(32'(n_start), 32'(s0));
        $display("test pin_trigger done");
        // Clock source and clock output
        bus(1'b1, ACS_OFS_GLOBAL, (32'(ACS_CLK_SRC_EXT) << ACS_GS_CLK_SRC_LO)
            | (32'h1 << ACS_GS_CLKOUT_EN));
        idle(3);
        check({31'h0, clock_source_ext}, 32'h00000001);
        check({31'h0, aux_oe}, 32'h00000001);
        t = aux_o;
        idle(1);
        check({31'h0, aux_o}, {31'h0, ~t});
        bus(1'b1, ACS_OFS_GLOBAL, 32'h00000000);
        idle(3);
        check({31'h0, aux_oe}, 32'h00000000);
        check({31'h0, clock_source_ext}, 32'h00000000);
        $display("test clock_pins done");
        finish_test();
    end
endmodule
